// ===== wwd_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Reset output released 16 internal cycles after supply exceeds reset threshold.
// - Supply below reset threshold pulls reset output low at once.
// - Armed by control bit 7, low supervisor voltage latches diagnosis bit 7.
// - After reset release the watchdog opens a 32-cycle long open window.
// - Trigger is control bit 0 sampled high two cycles, then low two.
// - Each period is 12 closed cycles then 20 open cycles.
// - Valid trigger in open window starts the next closed window immediately.
// - Early or missing trigger: reset low 4 cycles, diagnosis bit 2, long window.
// - Undervoltage or watchdog reset clears the whole control word.
// - Bit 8 plus undercurrent suspends watchdog and turns low-side switches off.
// - Leaving undercurrent gives one 32-cycle open window.
// - Flash level on pulse pin disables watchdog; first host telegram all zeros.
// - High-side 1 follows bit 1, or enabled pulse pin; serial bit dominates.
// - Diagnosis reports switch shutdown bit 14, prewarning bit 0, overload bit 1.
// - Supply lockout or any reset turns all switches off; lockout on bit 3.
// - High-side 2, 3 and low-side 1, 2 follow bits 2, 3, 5, 6.
// - Bits 3 and 4 pulse high-side 3 on 2 cycles per 128.
// - Diagnosis bits 5 and 6 show low-side switch states.
// - Word framed by chip select; taken on rising select, output released.
module wwd_supervisor #(
    parameter int unsigned TICK_DIV = wwd_pkg::TICK_DIV_DEF
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic vcc_above_reset,
    input wire logic vcc_above_supervisor,
    input wire logic undercurrent,
    input wire logic flash_level,
    input wire logic pulse_ctrl,
    input wire logic supply_lockout,
    input wire logic thermal_shutdown_sw,
    input wire logic thermal_prewarn,
    input wire logic hs1_overload,
    input wire logic thermal_shutdown_can,
    input wire logic [wwd_pkg::CAN_FAIL_W-1:0] can_failure,
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_din,
    output logic serial_dout,
    output logic serial_dout_oe_n,
    output logic reset_out,
    output logic high_side_out_1,
    output logic high_side_out_2,
    output logic high_side_out_3,
    output logic low_side_out_1,
    output logic low_side_out_2,
    output logic can_tx_enable,
    output logic can_not_standby
);
    import wwd_pkg::*;

    if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_div_check
        $error("TICK_DIV out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int unsigned PIN_W = 13 + CAN_FAIL_W;
    // Idle pin levels: select high, so no false frame edge follows reset
    localparam logic [PIN_W-1:0] PIN_IDLE = {{(PIN_W-2){1'b0}}, 2'h2};
    logic [PIN_W-1:0] pins, sync1_q, sync2_q;
    logic vcc_ok_s, vcc_sv_s, uc_s, flash_s, pwm_s, lockout_s, therm_sw_s, prewarn_s;
    logic ovl_s, therm_can_s, sclk_s, csn_s, din_s;
    logic [CAN_FAIL_W-1:0] can_fail_s;

    assign pins = {vcc_above_reset, vcc_above_supervisor, undercurrent, flash_level,
        pulse_ctrl, supply_lockout, thermal_shutdown_sw, thermal_prewarn, hs1_overload,
        thermal_shutdown_can, can_failure, serial_clk, chip_select_n, serial_din};
    assign {vcc_ok_s, vcc_sv_s, uc_s, flash_s, pwm_s, lockout_s, therm_sw_s, prewarn_s,
        ovl_s, therm_can_s, can_fail_s, sclk_s, csn_s, din_s} = sync2_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= PIN_IDLE;
            sync2_q <= PIN_IDLE;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal cycle tick
    logic [DIV_W-1:0] div_q, div_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = 1'b0;
        div_d = div_q + 16'h0001;
        if (div_q == DIV_W'(TICK_DIV - 1)) begin
            div_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial port
    logic [WORD_W-1:0] diag_word, rx_word;
    logic word_valid;

    wwd_serial u_serial (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sclk_s(sclk_s),
        .chip_select_n_s(csn_s),
        .din_s(din_s),
        .diag_word(diag_word),
        .rx_word(rx_word),
        .word_valid(word_valid),
        .dout(serial_dout),
        .dout_oe_n(serial_dout_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reset generator and window watchdog
    wwd_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] hist_q, hist_d;
    logic [WORD_W-1:0] ctrl_q, ctrl_d;
    logic trig, wd_fault, suspend, rst_q, rst_d;

    assign suspend = ctrl_q[CB_WD_CTRL] && uc_s;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        hist_d = hist_q;
        wd_fault = 1'b0;
        if (tick_q) begin
            hist_d = {hist_q[2:0], ctrl_q[CB_TRIG]};
        end
        trig = tick_q && (hist_d == TRIG_PATTERN) && !flash_s;
        if (!vcc_ok_s) begin
            st_d = ST_POR;
            cnt_d = '0;
        end else begin
            unique case (st_q)
                ST_POR: if (tick_q) begin
                    if (cnt_q == POR_TICKS - 6'h01) begin
                        st_d = ST_LONG;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                ST_LONG: if (flash_s) begin
                    cnt_d = '0;
                end else if (suspend) begin
                    st_d = ST_SUSP;
                end else if (trig) begin
                    st_d = ST_CLOSED;
                    cnt_d = '0;
                end else if (tick_q) begin
                    if (cnt_q == LONG_OPEN_TICKS - 6'h01) begin
                        wd_fault = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                ST_CLOSED: if (flash_s) begin
                    st_d = ST_LONG;
                    cnt_d = '0;
                end else if (suspend) begin
                    st_d = ST_SUSP;
                end else if (trig) begin
                    wd_fault = 1'b1;
                end else if (tick_q) begin
                    if (cnt_q == CLOSED_TICKS - 6'h01) begin
                        st_d = ST_OPEN;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                ST_OPEN: if (flash_s) begin
                    st_d = ST_LONG;
                    cnt_d = '0;
                end else if (suspend) begin
                    st_d = ST_SUSP;
                end else if (trig) begin
                    st_d = ST_CLOSED;
                    cnt_d = '0;
                end else if (tick_q) begin
                    if (cnt_q == OPEN_TICKS - 6'h01) begin
                        wd_fault = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                ST_SUSP: if (!suspend) begin
                    st_d = ST_LONG;
                    cnt_d = '0;
                end
                ST_WDRST: if (tick_q) begin
                    if (cnt_q == WDRST_TICKS - 6'h01) begin
                        st_d = ST_LONG;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                default: begin
                    st_d = ST_POR;
                    cnt_d = '0;
                end
            endcase
            if (wd_fault) begin
                st_d = ST_WDRST;
                cnt_d = '0;
            end
        end
        rst_d = (st_d != ST_POR) && (st_d != ST_WDRST);
        ctrl_d = ctrl_q;
        if (word_valid) begin
            ctrl_d = rx_word;
        end
        if (!vcc_ok_s || wd_fault) begin
            ctrl_d = CTRL_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_POR;
            cnt_q <= '0;
            hist_q <= '0;
            rst_q <= 1'b0;
            ctrl_q <= CTRL_RESET;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hist_q <= hist_d;
            rst_q <= rst_d;
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switches and auto-timing
    logic [AUTO_W-1:0] auto_q, auto_d;
    logic hs1_q, hs1_d, hs2_q, hs2_d, hs3_q, hs3_d, ls1_q, ls1_d, ls2_q, ls2_d;
    logic tx_q, tx_d, nstby_q, nstby_d, sw_on, auto_mode;

    assign auto_mode = ctrl_q[CB_HS3] && ctrl_q[CB_AUTO];

    always_comb begin
        sw_on = rst_d && !lockout_s;
        auto_d = auto_q;
        if (!auto_mode || wd_fault) begin
            auto_d = '0;
        end else if (tick_q) begin
            auto_d = auto_q + 7'h01;
        end
        hs1_d = sw_on && (ctrl_q[CB_HS1] || (ctrl_q[CB_PWM_EN] && pwm_s));
        hs2_d = sw_on && ctrl_q[CB_HS2];
        hs3_d = sw_on && ctrl_q[CB_HS3] && (!ctrl_q[CB_AUTO] || auto_q < AUTO_ON_TICKS);
        ls1_d = sw_on && ctrl_q[CB_LS1] && !suspend;
        ls2_d = sw_on && ctrl_q[CB_LS2] && !suspend;
        tx_d = ctrl_q[CB_CAN_TX];
        nstby_d = ctrl_q[CB_CAN_NSTBY];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            auto_q <= '0;
            hs1_q <= 1'b0;
            hs2_q <= 1'b0;
            hs3_q <= 1'b0;
            ls1_q <= 1'b0;
            ls2_q <= 1'b0;
            tx_q <= 1'b0;
            nstby_q <= 1'b0;
        end else begin
            auto_q <= auto_d;
            hs1_q <= hs1_d;
            hs2_q <= hs2_d;
            hs3_q <= hs3_d;
            ls1_q <= ls1_d;
            ls2_q <= ls2_d;
            tx_q <= tx_d;
            nstby_q <= nstby_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Diagnosis flags and word
    logic wdf_q, wdf_d, sv_q, sv_d;

    always_comb begin
        // Flags cleared after a completed frame; a new set wins
        wdf_d = wdf_q;
        sv_d = sv_q;
        if (word_valid) begin
            wdf_d = 1'b0;
            sv_d = 1'b0;
        end
        if (wd_fault) begin
            wdf_d = 1'b1;
        end
        if (ctrl_q[CB_SV_EN] && !vcc_sv_s) begin
            sv_d = 1'b1;
        end
        diag_word = '0;
        diag_word[DB_PREWARN] = prewarn_s;
        diag_word[DB_HS1_OVL] = ovl_s;
        diag_word[DB_THERM_SW] = therm_sw_s;
        diag_word[DB_WD_RST] = wdf_q;
        diag_word[DB_LOCKOUT] = lockout_s;
        diag_word[DB_LS1] = ls1_q;
        diag_word[DB_LS2] = ls2_q;
        diag_word[DB_SV] = sv_q;
        diag_word[DB_CAN_LO +: CAN_FAIL_W] = can_fail_s;
        diag_word[DB_THERM_CAN] = therm_can_s;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wdf_q <= 1'b0;
            sv_q <= 1'b0;
        end else begin
            wdf_q <= wdf_d;
            sv_q <= sv_d;
        end
    end

    assign reset_out = rst_q;
    assign high_side_out_1 = hs1_q;
    assign high_side_out_2 = hs2_q;
    assign high_side_out_3 = hs3_q;
    assign low_side_out_1 = ls1_q;
    assign low_side_out_2 = ls2_q;
    assign can_tx_enable = tx_q;
    assign can_not_standby = nstby_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_fault;
        wd_fault;
    endsequence
    sequence s_rst_entered;
        !reset_out && (st_q == ST_WDRST) && (cnt_q == '0);
    endsequence

    property p_uv_reset;
        !vcc_ok_s |=> !reset_out;
    endproperty
    a_uv_reset: assert property (p_uv_reset) else $error("reset not low on undervoltage");

    property p_por_release;
        $rose(reset_out) |-> $past(tick_q) &&
            (($past(st_q) == ST_POR && $past(cnt_q) == POR_TICKS - 6'h01) ||
            ($past(st_q) == ST_WDRST && $past(cnt_q) == WDRST_TICKS - 6'h01));
    endproperty
    a_por_release: assert property (p_por_release) else $error("early reset release");

    property p_long_start;
        $rose(reset_out) |-> st_q == ST_LONG && cnt_q == '0;
    endproperty
    a_long_start: assert property (p_long_start) else $error("no long window");

    property p_fault;
        s_fault |=> s_rst_entered ##0 wdf_q;
    endproperty
    a_fault: assert property (p_fault) else $error("watchdog reset missing");

    property p_ctrl_clear;
        s_fault |=> ctrl_q == CTRL_RESET;
    endproperty
    a_ctrl_clear: assert property (p_ctrl_clear) else $error("control not cleared");

    property p_good_trig;
        (st_q == ST_OPEN) && trig && vcc_ok_s && !suspend |=> st_q == ST_CLOSED && cnt_q == '0;
    endproperty
    a_good_trig: assert property (p_good_trig) else $error("closed window not started");

    property p_suspend_ls;
        suspend |=> !low_side_out_1 && !low_side_out_2;
    endproperty
    a_suspend_ls: assert property (p_suspend_ls) else $error("low side on in suspend");

    property p_lockout;
        lockout_s |=> !(high_side_out_1 || high_side_out_2 || high_side_out_3 ||
            low_side_out_1 || low_side_out_2);
    endproperty
    a_lockout: assert property (p_lockout) else $error("switch on in lockout");

    property p_hs1;
        ctrl_q[CB_HS1] && rst_d && !lockout_s |=> high_side_out_1;
    endproperty
    a_hs1: assert property (p_hs1) else $error("high side 1 not on");

    property p_flash;
        flash_s && vcc_ok_s && reset_out |=> !wd_fault [*2];
    endproperty
    a_flash: assert property (p_flash) else $error("watchdog active in flash");
endmodule : wwd_supervisor
`default_nettype wire

// ===== wwd_pkg.sv
`default_nettype none
package wwd_pkg;
    // System clock and internal cycle
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned TCYL_NS = 40000;
    localparam int unsigned TICK_DIV_DEF = TCYL_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W = 16;

    // Serial word
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BITS_W = 5;
    localparam logic [4:0] BITS_FULL = 5'h10;
    localparam logic [4:0] BITS_MAX = 5'h1F;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int unsigned CAN_FAIL_W = 6;

    // Control word bit positions
    localparam int unsigned CB_TRIG = 0;
    localparam int unsigned CB_HS1 = 1;
    localparam int unsigned CB_HS2 = 2;
    localparam int unsigned CB_HS3 = 3;
    localparam int unsigned CB_AUTO = 4;
    localparam int unsigned CB_LS1 = 5;
    localparam int unsigned CB_LS2 = 6;
    localparam int unsigned CB_SV_EN = 7;
    localparam int unsigned CB_WD_CTRL = 8;
    localparam int unsigned CB_CAN_NSTBY = 9;
    localparam int unsigned CB_CAN_TX = 10;
    localparam int unsigned CB_PWM_EN = 11;

    // Diagnosis word bit positions
    localparam int unsigned DB_PREWARN = 0;
    localparam int unsigned DB_HS1_OVL = 1;
    localparam int unsigned DB_WD_RST = 2;
    localparam int unsigned DB_LOCKOUT = 3;
    localparam int unsigned DB_LS1 = 5;
    localparam int unsigned DB_LS2 = 6;
    localparam int unsigned DB_SV = 7;
    localparam int unsigned DB_CAN_LO = 8;
    localparam int unsigned DB_THERM_SW = 14;
    localparam int unsigned DB_THERM_CAN = 15;

    // Counts in internal cycles
    localparam int unsigned CNT_W = 6;
    localparam logic [5:0] POR_TICKS = 6'h10;
    localparam logic [5:0] LONG_OPEN_TICKS = 6'h20;
    localparam logic [5:0] CLOSED_TICKS = 6'h0C;
    localparam logic [5:0] OPEN_TICKS = 6'h14;
    localparam logic [5:0] WDRST_TICKS = 6'h04;
    localparam logic [3:0] TRIG_PATTERN = 4'hC;
    localparam int unsigned AUTO_W = 7;
    localparam logic [6:0] AUTO_ON_TICKS = 7'h02;

    typedef enum logic [2:0] {
        ST_POR,
        ST_LONG,
        ST_CLOSED,
        ST_OPEN,
        ST_SUSP,
        ST_WDRST
    } wwd_state_t;
endpackage : wwd_pkg
`default_nettype wire

// ===== wwd_serial.sv
`timescale 1ns/100ps
`default_nettype none
module wwd_serial (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sclk_s,
    input wire logic chip_select_n_s,
    input wire logic din_s,
    input wire logic [wwd_pkg::WORD_W-1:0] diag_word,
    output logic [wwd_pkg::WORD_W-1:0] rx_word,
    output logic word_valid,
    output logic dout,
    output logic dout_oe_n
);
    import wwd_pkg::*;

    logic sclk_prev_q, csn_prev_q;
    logic [WORD_W-1:0] tx_q, tx_d, rx_q, rx_d, word_q, word_d;
    logic [BITS_W-1:0] bits_q, bits_d;
    logic valid_q, valid_d, dout_q, dout_d, oe_n_q, oe_n_d;
    logic cs_fall, cs_rise, sclk_rise, sclk_fall;

    assign cs_fall = csn_prev_q && !chip_select_n_s;
    assign cs_rise = !csn_prev_q && chip_select_n_s;
    assign sclk_rise = !sclk_prev_q && sclk_s;
    assign sclk_fall = sclk_prev_q && !sclk_s;

    ////////////////////////////////////////////////////////////////////////////
    // Frame shifting: sample on rising clock, shift out on falling clock
    always_comb begin
        tx_d = tx_q;
        rx_d = rx_q;
        word_d = word_q;
        bits_d = bits_q;
        valid_d = 1'b0;
        dout_d = dout_q;
        oe_n_d = oe_n_q;
        if (cs_fall) begin
            tx_d = diag_word;
            dout_d = diag_word[WORD_W-1];
            oe_n_d = 1'b0;
            bits_d = '0;
        end else if (cs_rise) begin
            oe_n_d = 1'b1;
            if (bits_q == BITS_FULL) begin
                word_d = rx_q;
                valid_d = 1'b1;
            end
        end else if (!chip_select_n_s) begin
            if (sclk_rise) begin
                rx_d = {rx_q[WORD_W-2:0], din_s};
                if (bits_q != BITS_MAX) begin
                    bits_d = bits_q + 5'h01;
                end
            end
            if (sclk_fall) begin
                tx_d = {tx_q[WORD_W-2:0], 1'b0};
                dout_d = tx_q[WORD_W-2];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_q <= 1'b0;
            csn_prev_q <= 1'b1;
            tx_q <= '0;
            rx_q <= '0;
            word_q <= '0;
            bits_q <= '0;
            valid_q <= 1'b0;
            dout_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            csn_prev_q <= chip_select_n_s;
            tx_q <= tx_d;
            rx_q <= rx_d;
            word_q <= word_d;
            bits_q <= bits_d;
            valid_q <= valid_d;
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign rx_word = word_q;
    assign word_valid = valid_q;
    assign dout = dout_q;
    assign dout_oe_n = oe_n_q;
endmodule : wwd_serial
`default_nettype wire

// ===== wwd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module wwd_host_model (
    input wire logic sys_clk,
    input wire logic serial_dout,
    input wire logic serial_dout_oe_n,
    output logic serial_clk,
    output logic chip_select_n,
    output logic serial_din
);
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_din = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Framed 16-bit word
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        int i;
        chip_select_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        for (i = 15; i >= 0; i--) begin
            serial_din <= tx[i];
            repeat (4) @(posedge sys_clk);
            serial_clk <= 1'b1;
            rx[i] = serial_dout_oe_n ? ~serial_dout : serial_dout;
            repeat (4) @(posedge sys_clk);
            serial_clk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        chip_select_n <= 1'b1;
        serial_din <= ~tx[0];
        repeat (8) @(posedge sys_clk);
    endtask : xfer
endmodule : wwd_host_model
`default_nettype wire

// ===== wwd_supervisor_test.sv
`timescale 1ns/100ps
`default_nettype none
module wwd_supervisor_test;
    import wwd_pkg::*;
    localparam int unsigned TDIV = 32;
    logic sys_clk, resetn, vcc_above_reset, vcc_above_supervisor, undercurrent;
    logic flash_level, pulse_ctrl, supply_lockout, thermal_shutdown_sw, thermal_prewarn;
    logic hs1_overload, thermal_shutdown_can, serial_clk, chip_select_n, serial_din;
    logic serial_dout, serial_dout_oe_n, reset_out, high_side_out_1, high_side_out_2;
    logic high_side_out_3, low_side_out_1, low_side_out_2, can_tx_enable, can_not_standby;
    logic [CAN_FAIL_W-1:0] can_failure;
    logic [15:0] rx;
    logic [6:0] outs;
    int errors = 0;
    int tests_run = 0;
    int n;
    assign outs = {high_side_out_1, high_side_out_2, high_side_out_3, low_side_out_1,
        low_side_out_2, can_tx_enable, can_not_standby};
    wwd_supervisor #(.TICK_DIV(TDIV)) i_dut (.sys_clk, .resetn, .vcc_above_reset,
        .vcc_above_supervisor, .undercurrent, .flash_level, .pulse_ctrl, .supply_lockout,
        .thermal_shutdown_sw, .thermal_prewarn, .hs1_overload, .thermal_shutdown_can,
        .can_failure, .serial_clk, .chip_select_n, .serial_din, .serial_dout,
        .serial_dout_oe_n, .reset_out, .high_side_out_1, .high_side_out_2, .high_side_out_3,
        .low_side_out_1, .low_side_out_2, .can_tx_enable, .can_not_standby);
    wwd_host_model i_host (.sys_clk, .serial_dout, .serial_dout_oe_n, .serial_clk,
        .chip_select_n, .serial_din);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : cyc
    task automatic trig(input logic [15:0] w);
        i_host.xfer(w | 16'h0001, rx);
        cyc(3 * TDIV);
        i_host.xfer(w, rx);
        cyc(3 * TDIV);
    endtask : trig
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #1000000;
        errors++;
        conclude;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        vcc_above_reset = 1'b0;
        vcc_above_supervisor = 1'b1;
        undercurrent = 1'b0;
        flash_level = 1'b0;
        pulse_ctrl = 1'b0;
        supply_lockout = 1'b0;
        thermal_shutdown_sw = 1'b1;
        thermal_prewarn = 1'b1;
        hs1_overload = 1'b1;
        thermal_shutdown_can = 1'b1;
        can_failure = 6'h2A;
        cyc(12);
        resetn <= 1'b1;
        cyc(5);
        vcc_above_reset <= 1'b1;
        cyc(500);
        check(16'(reset_out), 16'h0000);
        cyc(60);
        check(16'(reset_out), 16'h0001);
        $display("test power-on done");
        i_host.xfer(16'h066E, rx);
        check(rx, 16'hEA03);
        i_host.xfer(16'h066E, rx);
        check(rx, 16'hEA63);
        check(16'(outs), 16'h007F);
        for (n = 0; n < 3; n++) begin
            trig(16'h066E);
            check(16'(reset_out), 16'h0001);
            cyc(4 * TDIV);
        end
        $display("test triggers done");
        n = 0;
        while (reset_out !== 1'b0 && n < 1600) begin
            cyc(1);
            n++;
        end
        check(16'(n < 1600), 16'h0001);
        n = 0;
        while (reset_out !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        check(16'(n >= 120 && n <= 136), 16'h0001);
        check(16'(outs), 16'h0000);
        i_host.xfer(16'h0880, rx);
        check(rx, 16'hEA07);
        $display("test fault done");
        pulse_ctrl <= 1'b1;
        cyc(6);
        check(16'(high_side_out_1), 16'h0001);
        pulse_ctrl <= 1'b0;
        cyc(6);
        check(16'(high_side_out_1), 16'h0000);
        pulse_ctrl <= 1'b1;
        vcc_above_supervisor <= 1'b0;
        supply_lockout <= 1'b1;
        cyc(6);
        check(16'(high_side_out_1), 16'h0000);
        vcc_above_supervisor <= 1'b1;
        i_host.xfer(16'h0880, rx);
        check(rx, 16'hEA8B);
        $display("test switches done");
        supply_lockout <= 1'b0;
        flash_level <= 1'b1;
        cyc(4);
        i_host.xfer(16'h0000, rx);
        cyc(40 * TDIV);
        check(16'(reset_out), 16'h0001);
        $display("test flash done");
        i_host.xfer(16'h0178, rx);
        while (high_side_out_3 !== 1'b0) begin
            cyc(1);
        end
        n = 0;
        while (high_side_out_3 !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        check(16'(n), 16'(126 * TDIV));
        n = 0;
        while (high_side_out_3 !== 1'b0 && n < 5000) begin
            cyc(1);
            n++;
        end
        check(16'(n), 16'(2 * TDIV));
        check(16'({low_side_out_1, low_side_out_2}), 16'h0003);
        undercurrent <= 1'b1;
        cyc(6);
        check(16'({low_side_out_1, low_side_out_2}), 16'h0000);
        flash_level <= 1'b0;
        cyc(40 * TDIV);
        check(16'(reset_out), 16'h0001);
        undercurrent <= 1'b0;
        n = 0;
        while (reset_out !== 1'b0 && n < 2000) begin
            cyc(1);
            n++;
        end
        check(16'(n >= 31 * TDIV && n <= 33 * TDIV), 16'h0001);
        cyc(5 * TDIV);
        check(16'(reset_out), 16'h0001);
        vcc_above_reset <= 1'b0;
        cyc(5);
        check(16'(reset_out), 16'h0000);
        $display("test suspend and undervoltage done");
        conclude;
    end
endmodule : wwd_supervisor_test
`default_nettype wire
